// ---- rtl/imef_top.sv ----
// Overview of operation
// R1: Suspended flag sets when last byte finishes shifting after suspend request.
// R2: While suspended, all bus traffic stays paused until resume arrives; a stopped event from the engine also releases pause here.
// R3: Receive-started flag sets when receive sequence begins after start task.
// R4: Last-receive flag sets at boundary where final buffer byte starts.
// R5: Software issues stop only when not suspended; stop there is ignored.
// R6: Each event register: bit 0, resets 0, sets on event, write 0 clears.
`timescale 1ns/10ps
`default_nettype none

module imef_top
  import imef_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  logic [DATA_W-1:0] reg_rdata,
  input  wire imef_core_t        core_evt,
  output var  imef_task_t        core_task,
  output var  logic              irq
);

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  function automatic logic [2:0] evt_index(input logic [ADDR_W-1:0] a);
    logic [2:0] idx;
    idx = EVT_NONE;
    for (int i = 0; i < EVT_N; i++) begin
      if (a == EVT_OFS[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // Tasks fire only on a one in bit 0
  function automatic logic task_hit(input logic              wr,
                                    input logic [ADDR_W-1:0] a,
                                    input logic [DATA_W-1:0] d,
                                    input logic [ADDR_W-1:0] ofs);
    return wr && (a == ofs) && d[0];
  endfunction

  logic             wr_rx;
  logic             wr_tx;
  logic             wr_stop;
  logic             wr_susp;
  logic             wr_res;
  logic             wr_max;
  logic             wr_ist;
  logic             wr_imask;
  logic [2:0]       wr_idx;
  logic [2:0]       rd_idx;

  always_comb begin
    wr_rx    = task_hit(reg_wr, reg_addr, reg_wdata, OFS_TASK_RX);
    wr_tx    = task_hit(reg_wr, reg_addr, reg_wdata, OFS_TASK_TX);
    wr_stop  = task_hit(reg_wr, reg_addr, reg_wdata, OFS_TASK_STOP);
    wr_susp  = task_hit(reg_wr, reg_addr, reg_wdata, OFS_TASK_SUSP);
    wr_res   = task_hit(reg_wr, reg_addr, reg_wdata, OFS_TASK_RES);
    wr_max   = reg_wr && (reg_addr == OFS_RX_MAX);
    wr_ist   = reg_wr && (reg_addr == OFS_IRQ_STAT);
    wr_imask = reg_wr && (reg_addr == OFS_IRQ_MASK);
    wr_idx   = reg_wr ? evt_index(reg_addr) : EVT_NONE;
    rd_idx   = evt_index(reg_addr);
  end

  // ----------------------------------------
  // Receive buffer length
  // ----------------------------------------
  // Zero disables the last-byte event
  logic [15:0]      rx_max_r;
  logic [15:0]      rx_max_nxt;
  logic             rx_len_ok;

  always_comb begin
    rx_max_nxt = rx_max_r;
    if (wr_max) begin
      rx_max_nxt = reg_wdata[15:0];
    end
    rx_len_ok = rx_max_r != 16'h0000;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_max_r <= RX_MAX_RST;
    end else begin
      rx_max_r <= rx_max_nxt;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  imef_state_t      state_r;
  imef_state_t      state_nxt;
  logic             dir_rx_r;
  logic             dir_rx_nxt;
  logic             susp_req_r;
  logic             susp_req_nxt;
  logic [15:0]      rx_cnt_r;
  logic [15:0]      rx_cnt_nxt;
  logic [EVT_N-1:0] hit;

  always_comb begin
    state_nxt    = state_r;
    dir_rx_nxt   = dir_rx_r;
    susp_req_nxt = susp_req_r;
    rx_cnt_nxt   = rx_cnt_r;
    hit          = '0;
    case (state_r)
      IMEF_IDLE: begin
        if (wr_rx) begin
          state_nxt  = IMEF_RX_WAIT;
          dir_rx_nxt = 1'b1;
          rx_cnt_nxt = '0;
        end else if (wr_tx) begin
          state_nxt  = IMEF_TX_WAIT;
          dir_rx_nxt = 1'b0;
        end
      end
      IMEF_RX_WAIT: begin
        if (core_evt.seq_begin) begin
          state_nxt = IMEF_RX;
          hit[EV_RX_STARTED] = 1'b1; // [R3]
        end
      end
      IMEF_TX_WAIT: begin
        if (core_evt.seq_begin) begin
          state_nxt = IMEF_TX;
          hit[EV_TX_STARTED] = 1'b1;
        end
      end
      IMEF_RX, IMEF_TX: begin
        if (wr_susp) begin
          susp_req_nxt = 1'b1;
        end
        if (state_r == IMEF_RX && core_evt.byte_bnd) begin
          rx_cnt_nxt = rx_cnt_r + 16'h0001;
          if (rx_len_ok && rx_cnt_r == rx_max_r - 16'h0001) begin
            hit[EV_LAST_RX] = 1'b1; // [R4]
          end
        end
        // Suspend only lands once the byte in flight is out
        if ((susp_req_r || wr_susp) && core_evt.byte_done) begin
          state_nxt    = IMEF_SUSP;
          susp_req_nxt = 1'b0;
          hit[EV_SUSPENDED] = 1'b1; // [R1]
        end
      end
      IMEF_SUSP: begin
        // Stop here is unsupported and simply dropped
        if (wr_res) begin // [R2] [R5]
          state_nxt = dir_rx_r ? IMEF_RX : IMEF_TX;
        end
      end
      default: begin
        state_nxt = IMEF_IDLE;
      end
    endcase
    if (core_evt.stopped) begin
      state_nxt    = IMEF_IDLE;
      susp_req_nxt = 1'b0;
      hit[EV_STOPPED] = 1'b1;
    end
    if (core_evt.error) begin
      hit[EV_ERROR] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r    <= IMEF_IDLE;
      dir_rx_r   <= 1'b0;
      susp_req_r <= 1'b0;
      rx_cnt_r   <= '0;
    end else begin
      state_r    <= state_nxt;
      dir_rx_r   <= dir_rx_nxt;
      susp_req_r <= susp_req_nxt;
      rx_cnt_r   <= rx_cnt_nxt;
    end
  end

  // ----------------------------------------
  // Task outputs
  // ----------------------------------------
  imef_task_t       task_nxt;

  always_comb begin
    task_nxt.start_rx = wr_rx && state_r == IMEF_IDLE;
    task_nxt.start_tx = wr_tx && !wr_rx && state_r == IMEF_IDLE;
    task_nxt.stop     = wr_stop && state_r != IMEF_SUSP; // [R5]
    // From next state, so pause rises with the suspended flag
    task_nxt.pause    = state_nxt == IMEF_SUSP; // [R2]
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      core_task <= '0;
    end else begin
      core_task <= task_nxt;
    end
  end

  // ----------------------------------------
  // Event flags
  // ----------------------------------------
  // Hardware set wins over a software clear in the same cycle
  logic [EVT_N-1:0] flag_r;
  logic [EVT_N-1:0] flag_nxt;

  for (genvar g = 0; g < EVT_N; g++) begin : g_flag
    always_comb begin
      flag_nxt[g] = flag_r[g];
      if (wr_idx == 3'(g)) begin
        flag_nxt[g] = reg_wdata[0]; // [R6]
      end
      if (hit[g]) begin
        flag_nxt[g] = 1'b1; // [R6]
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flag_r <= FLAG_RST; // [R6]
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  logic [EVT_N-1:0] ist_r;
  logic [EVT_N-1:0] ist_nxt;
  logic [EVT_N-1:0] imask_r;
  logic [EVT_N-1:0] imask_nxt;
  logic             irq_nxt;

  always_comb begin
    ist_nxt   = ist_r;
    imask_nxt = imask_r;
    if (wr_ist) begin
      ist_nxt = ist_r & ~reg_wdata[EVT_N-1:0];
    end
    if (wr_imask) begin
      imask_nxt = reg_wdata[EVT_N-1:0];
    end
    ist_nxt = ist_nxt | hit;
    // Next-state values, so irq rises with the flag
    irq_nxt = |(ist_nxt & imask_nxt);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ist_r   <= '0;
      imask_r <= '0;
      irq     <= 1'b0;
    end else begin
      ist_r   <= ist_nxt;
      imask_r <= imask_nxt;
      irq     <= irq_nxt;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Unmapped and write-only task addresses read as zero
  // Zero outside the read slot keeps stale data off the bus
  logic [DATA_W-1:0] rdata_nxt;

  always_comb begin
    rdata_nxt = '0;
    if (reg_rd) begin
      if (rd_idx != EVT_NONE) begin
        rdata_nxt[0] = flag_r[rd_idx];
      end else begin
        case (reg_addr)
          OFS_RX_MAX:   rdata_nxt[15:0] = rx_max_r;
          OFS_STATE:    rdata_nxt[2:0]  = 3'(state_r);
          OFS_IRQ_STAT: rdata_nxt[EVT_N-1:0] = ist_r;
          OFS_IRQ_MASK: rdata_nxt[EVT_N-1:0] = imask_r;
          default:      rdata_nxt = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/imef_pkg.sv ----
package imef_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 32;
  localparam int          EVT_N          = 6;
  localparam logic [11:0] OFS_TASK_RX    = 12'h000;
  localparam logic [11:0] OFS_TASK_TX    = 12'h008;
  localparam logic [11:0] OFS_TASK_STOP  = 12'h014;
  localparam logic [11:0] OFS_TASK_SUSP  = 12'h01c;
  localparam logic [11:0] OFS_TASK_RES   = 12'h020;
  localparam logic [11:0] OFS_RX_MAX     = 12'h600;
  localparam logic [11:0] OFS_STATE      = 12'h604;
  localparam logic [11:0] OFS_IRQ_STAT   = 12'h608;
  localparam logic [11:0] OFS_IRQ_MASK   = 12'h60c;

  // Event flag order: index into the flag array
  localparam int          EV_STOPPED     = 0;
  localparam int          EV_ERROR       = 1;
  localparam int          EV_SUSPENDED   = 2;
  localparam int          EV_RX_STARTED  = 3;
  localparam int          EV_TX_STARTED  = 4;
  localparam int          EV_LAST_RX     = 5;
  localparam logic [11:0] EVT_OFS [EVT_N] = '{
    12'h104, 12'h124, 12'h148, 12'h14c, 12'h150, 12'h15c
  };
  localparam logic [2:0]  EVT_NONE       = 3'h7;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] RX_MAX_RST     = 16'h0001;
  localparam logic [EVT_N-1:0] FLAG_RST  = 6'h00;

  typedef enum {
    IMEF_IDLE, IMEF_RX_WAIT, IMEF_RX, IMEF_TX_WAIT, IMEF_TX, IMEF_SUSP
  } imef_state_t;

  // Events reported by the bit engine, same clock
  typedef struct packed {
    logic seq_begin;
    logic byte_bnd;
    logic byte_done;
    logic stopped;
    logic error;
  } imef_core_t;

  // Task pulses and the held pause level towards the bit engine
  typedef struct packed {
    logic start_rx;
    logic start_tx;
    logic stop;
    logic pause;
  } imef_task_t;

endpackage

// ---- tb/imef_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module imef_asserts
  import imef_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire imef_core_t        core_evt,
  input wire imef_task_t        core_task,
  input wire logic              irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Task write sequences
  // ----------------------------------------
  sequence s_go(a);
    reg_wr && reg_addr == a && reg_wdata[0];
  endsequence
  sequence s_held;
    core_task.pause && !core_evt.stopped;
  endsequence
  property p_susp;
    $rose(core_task.pause) |-> $past(core_evt.byte_done);
  endproperty
  a_susp: assert property (p_susp)
    else $error("pause rose without a finished byte");
  property p_hold;
    s_held ##0 !reg_wr |=> core_task.pause;
  endproperty
  a_hold: assert property (p_hold)
    else $error("pause dropped without resume");
  property p_res;
    s_go(OFS_TASK_RES) ##0 core_task.pause |=> !core_task.pause;
  endproperty
  a_res: assert property (p_res)
    else $error("resume did not release pause");
  property p_nostop;
    core_task.pause ##0 s_go(OFS_TASK_STOP) |=> !core_task.stop;
  endproperty
  a_nostop: assert property (p_nostop)
    else $error("stop forwarded while paused");
  property p_rxgo;
    core_task.start_rx |-> $past(reg_wr && reg_addr == OFS_TASK_RX);
  endproperty
  a_rxgo: assert property (p_rxgo)
    else $error("receive start without task write");
  property p_bit0;
    reg_rd && reg_addr[11:8] == 4'h1 |=> reg_rdata[31:1] == '0;
  endproperty
  a_bit0: assert property (p_bit0)
    else $error("event register upper bits set");
  property p_idle;
    !reg_rd |=> reg_rdata == '0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("read data outside read slot");
endmodule
bind imef_top imef_asserts u_chk (.clk_sys, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .core_evt, .core_task, .irq);
`default_nettype wire

// ---- tb/imef_peer.sv ----
`timescale 1ns/10ps
`default_nettype none
module imef_peer
  import imef_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire imef_core_t kick,
  input  wire imef_task_t core_task,
  output var  imef_core_t core_evt
);
  // Bus engine stand-in; byte events come from the bench
  logic [1:0] sb_r;
  logic [1:0] st_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sb_r <= 2'h0;
      st_r <= 2'h0;
    end else begin
      sb_r <= {sb_r[0], core_task.start_rx | core_task.start_tx};
      st_r <= {st_r[0], core_task.stop};
    end
  end
  assign core_evt = imef_core_t'(kick | {sb_r[1], 2'h0, st_r[1], 1'h0});
endmodule
`default_nettype wire

// ---- tb/i2c_master_event_flags_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module i2c_master_event_flags_bench
  import imef_pkg::*;
;
  localparam logic [31:0] ONE = 32'h0000_0001;
  logic              clk_sys, sys_rst, reg_wr, reg_rd, irq;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  imef_core_t        core_evt, kick;
  imef_task_t        core_task;
  int                error_cnt, checks_done;
  imef_top dut (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .core_evt, .core_task, .irq);
  imef_peer peer (.clk_sys, .sys_rst, .kick, .core_task, .core_evt);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), reg_rdata, e);
  endtask
  task automatic ev(input logic [4:0] k);
    @(posedge clk_sys);
    kick <= imef_core_t'(k);
    @(posedge clk_sys);
    kick <= '0;
    #1;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Hang guard; far above the longest sequence
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    close_out();
  end
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, kick} = '0;
    error_cnt = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < EVT_N; i++) rd(EVT_OFS[i], '0);
    rd(12'h700, '0);
    wr(OFS_IRQ_MASK, ONE);
    wr(OFS_RX_MAX, 32'h0000_0002);
    rd(OFS_RX_MAX, 32'h0000_0002);
    wr(OFS_TASK_RX, ONE);
    tick(4);
    rd(EVT_OFS[EV_RX_STARTED], ONE);
    rd(EVT_OFS[EV_TX_STARTED], '0);
    ev(5'h08);
    rd(EVT_OFS[EV_LAST_RX], '0);
    ev(5'h08);
    rd(EVT_OFS[EV_LAST_RX], ONE);
    wr(OFS_TASK_SUSP, ONE);
    rd(EVT_OFS[EV_SUSPENDED], '0);
    ev(5'h04);
    chk("pause", core_task.pause, ONE);
    rd(EVT_OFS[EV_SUSPENDED], ONE);
    rd(OFS_STATE, 32'h0000_0005);
    wr(OFS_TASK_STOP, ONE);
    tick(4);
    chk("pause", core_task.pause, ONE);
    rd(EVT_OFS[EV_STOPPED], '0);
    ev(5'h01);
    chk("irq", irq, '0);
    wr(OFS_TASK_RES, ONE);
    chk("pause", core_task.pause, '0);
    wr(OFS_TASK_STOP, ONE);
    tick(4);
    rd(EVT_OFS[EV_STOPPED], ONE);
    chk("irq", irq, ONE);
    wr(OFS_IRQ_STAT, ONE);
    tick(1);
    chk("irq", irq, '0);
    // Error, suspended, receive started and last receive stay pending
    rd(OFS_IRQ_STAT, 32'h0000_002e);
    rd(OFS_IRQ_MASK, ONE);
    wr(OFS_TASK_TX, ONE);
    tick(4);
    wr(EVT_OFS[EV_LAST_RX], '0);
    // Stopped, error, suspended, both starts set; last cleared
    for (int i = 0; i < EVT_N; i++) rd(EVT_OFS[i], {31'h0, i < 5});
    close_out();
  end
endmodule
`default_nettype wire
